//--- dv/ple_engine_chk_asserts.sv
`timescale 1ns/1ps
`include "ple_defs.vh"
module ple_engine_chk #(
    parameter SVC_CYCLES = 20
) (
    input wire clk_sys,
    input wire rst_b,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire condition_accumulator,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire serial_service
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    reg rd_q;
    reg seen;
    reg [31:0] a_q;
    integer gap;
    // read data phase follows every taken read address phase
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_q <= 1'b0;
            a_q <= 32'h0;
            seen <= 1'b0;
            gap <= 0;
        end else begin
            rd_q <= hsel && hready && htrans[1] && !hwrite;
            a_q <= haddr;
            seen <= seen | serial_service;
            gap <= serial_service ? 1 : gap + 1;
        end
    end
    AST_READY: assert property (hreadyout) else $error("wait state seen");
    AST_OKAY: assert property (!hresp) else $error("error response");
    AST_SVC_PULSE: assert property (
        serial_service |=> !serial_service)
        else $error("service pulse too long");
    AST_SVC_GAP: assert property (
        seen && serial_service |-> gap == SVC_CYCLES)
        else $error("service interval wrong");
    AST_SVC_MAX: assert property (seen |-> gap <= SVC_CYCLES)
        else $error("service pulse missing");
    AST_RD_HOLD: assert property (!rd_q |-> $stable(hrdata))
        else $error("read data moved");
    AST_UNMAP: assert property (
        rd_q && a_q > `PLE_OFF_SVC_CNT |-> hrdata == 0)
        else $error("unmapped read not zero");
    AST_STAT: assert property (
        rd_q && a_q == `PLE_OFF_STATUS |-> hrdata[31:3] == 0)
        else $error("status spare bits set");
    AST_CNT16: assert property (
        rd_q && a_q == `PLE_OFF_CNT_DATA |-> hrdata < 32'h10000)
        else $error("counter wider than 16 bits");
    AST_HIST: assert property (
        rd_q && a_q == `PLE_OFF_HIST_SEL |-> hrdata < 32'h8000)
        else $error("stored output out of range");
endmodule // ple_engine_chk
bind ple_pid_loop_engine ple_engine_chk #(.SVC_CYCLES(SVC_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .condition_accumulator(condition_accumulator),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .serial_service(serial_service));

//--- dv/ple_pid_loop_engine_test.sv
`timescale 1ns/1ps
`include "ple_defs.vh"
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module ple_pid_loop_engine_test;
    logic clk_sys = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic condition_accumulator = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, serial_service;
    logic [4:0] lp = 5'd0, mblk;
    logic [15:0] mfi, mfd, mfp;
    logic [15:0] ptab [7];
    logic [8:0] xa, ca;
    wire hready = hreadyout;
    int err_count = 0, n_compared = 0;
    always #20 clk_sys = ~clk_sys;
    ple_pid_loop_engine #(.SVC_CYCLES(20)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .condition_accumulator(condition_accumulator),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .serial_service(serial_service));
    ple_prog_model pm (.loop_idx(lp), .blk(mblk), .fi(mfi), .fd(mfd),
        .fp(mfp));
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task wait_rdy;
        int i;
        i = 0;
        @(posedge clk_sys);
        while (hready !== 1'b1) begin
            i++;
            if (i > 50) begin
                err_count++;
                end_sim;
            end
            @(posedge clk_sys);
        end
    endtask
    task xfer(input logic w, input logic [31:0] a, d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rv = hrdata;
    endtask
    task cw(input logic [8:0] a, input logic [15:0] v);
        xfer(1'b1, `PLE_OFF_CNT_ADDR, {23'h0, a});
        xfer(1'b1, `PLE_OFF_CNT_DATA, {16'h0, v});
    endtask
    task cr(input logic [8:0] a);
        xfer(1'b1, `PLE_OFF_CNT_ADDR, {23'h0, a});
        xfer(1'b0, `PLE_OFF_CNT_DATA, 32'h0);
    endtask
    task step(input logic [9:0] op, input logic [4:0] res, bl,
        input logic [15:0] w, fi, fd, fp, db, input logic [7:0] al);
        int i;
        xfer(1'b1, `PLE_OFF_INSTR0, {11'h0, bl, 1'b0, res, op});
        xfer(1'b1, `PLE_OFF_INSTR1, {7'h0, xa, w});
        xfer(1'b1, `PLE_OFF_INSTR2, {fd, fi});
        xfer(1'b1, `PLE_OFF_INSTR3, {db, fp});
        xfer(1'b1, `PLE_OFF_INSTR4, {8'h0, al, 7'h0, ca});
        xfer(1'b1, `PLE_OFF_CTRL, 32'h1);
        // busy rises on the same edge that the go write lands
        repeat (2) @(posedge clk_sys);
        i = 0;
        do begin
            xfer(1'b0, `PLE_OFF_STATUS, 32'h0);
            i++;
        end while (rv[1:0] !== 2'b10 && i < 200);
        `CHK(rv[1:0], 2'b10);
        if (rv[1:0] !== 2'b10) end_sim;
    endtask
    task hist(input logic [4:0] b, input logic [15:0] e);
        xfer(1'b1, `PLE_OFF_HIST_SEL, {27'h0, b});
        xfer(1'b0, `PLE_OFF_HIST_SEL, 32'h0);
        `CHK(rv, {16'h0, e});
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        cw(9'd256, 16'h1234);
        cw(9'd319, 16'h7FFF);
        cr(9'd256);
        `CHK(rv, 32'h1234);
        cr(9'd319);
        `CHK(rv, 32'h7FFF);
        xfer(1'b1, 32'h3C, 32'h5A5A);
        xfer(1'b0, 32'h3C, 32'h0);
        `CHK(rv, 32'h0);
        // cold start through each opcode, one loop each
        for (int k = 0; k < 3; k++) begin
            lp = k[4:0];
            condition_accumulator <= k[0];
            @(posedge clk_sys);
            xa = (k == 2) ? 9'd281 : 9'd260;
            ca = (k == 2) ? 9'd286 : 9'd300;
            ptab = '{16'd0, 16'd500, mfi, mfd, mfp, 16'd0, 16'd100 + 16'(k)};
            for (int j = 0; j < 7; j++) cw(9'd280 + 9'(j), ptab[j]);
            cw(9'd260, 16'd500);
            cw(9'd270, 16'd0);
            cw(9'd300, 16'd100 + 16'(k));
            step(10'd210 + 10'(k), 5'd12, mblk, (k == 0) ? 16'd0 :
                (k == 1 ? 16'd270 : 16'd280), mfi, mfd, mfp, 16'd0, 8'h0);
            cr(xa);
            `CHK(rv, 32'd100 + 32'(k));
            cr(ca);
            `CHK(rv, 32'h0);
            hist(mblk, 16'd100 + 16'(k));
        end
        xa = 9'd260;
        ca = 9'd300;
        cw(9'd260, 16'd0);
        cw(9'd300, 16'd1);
        step(10'd210, 5'd8, 5'd31, 16'd1, 16'd256, 16'd0, 16'd256, 16'd0, 8'h0);
        cr(9'd260);
        `CHK(rv, 32'd1);
        cw(9'd270, 16'd255);
        // periodic calls reuse the history of the same loop
        step(10'd211, 5'd8, 5'd31, 16'd270, 16'd256, 16'd0, 16'd8191,
            16'd0, 8'h0);
        cr(9'd260);
        `CHK(rv, 32'd255);
        step(10'd210, 5'd8, 5'd31, 16'd0, 16'd256, 16'd0, 16'd8191,
            16'd255, 8'h0);
        cr(9'd260);
        `CHK(rv, 32'd255);
        xfer(1'b0, `PLE_OFF_STATUS, 32'h0);
        `CHK(rv[2], 1'b1);
        cw(9'd300, 16'd20000);
        step(10'd210, 5'd15, 5'd31, 16'd0, 16'd256, 16'd0, 16'd256,
            16'd0, 8'h1);
        cr(9'd260);
        `CHK(rv, 32'd20000);
        hist(5'd29, 16'd102);
        end_sim;
    end
endmodule // ple_pid_loop_engine_test

//--- dv/ple_prog_model.sv
`timescale 1ns/1ps
// loop parameters as the user program hands them to the engine
module ple_prog_model (
    input wire [4:0] loop_idx,
    output wire [4:0] blk,
    output wire [15:0] fi,
    output wire [15:0] fd,
    output wire [15:0] fp
);
    // history blocks taken from the top down
    assign blk = 5'd31 - loop_idx;
    // gains are factor times 256, kept as multiple of 2048 plus remainder
    assign fi = {5'h0, 11'h100};
    assign fd = {5'h0, 11'h000};
    assign fp = {5'h1, 11'h0C5 + {6'h0, loop_idx}};
endmodule // ple_prog_model

//--- rtl/ple_defs.vh
`ifndef PLE_DEFS_VH
`define PLE_DEFS_VH
// ahb register byte offsets
`define PLE_OFF_CTRL 8'h00
`define PLE_OFF_STATUS 8'h04
`define PLE_OFF_INSTR0 8'h08
`define PLE_OFF_INSTR1 8'h0C
`define PLE_OFF_INSTR2 8'h10
`define PLE_OFF_INSTR3 8'h14
`define PLE_OFF_INSTR4 8'h18
`define PLE_OFF_CNT_ADDR 8'h1C
`define PLE_OFF_CNT_DATA 8'h20
`define PLE_OFF_HIST_SEL 8'h24
`define PLE_OFF_SVC_CNT 8'h28
// opcodes
`define PLE_OP_IMM 10'd210
`define PLE_OP_CNT 10'd211
`define PLE_OP_BLK 10'd212
// resolution codes
`define PLE_RES_8 5'd8
`define PLE_RES_12 5'd12
`define PLE_RES_15 5'd15
// counter window
`define PLE_CNT_BASE 9'd256
`define PLE_CNT_LAST 9'd319
`define PLE_CNT_NUM 64
`define PLE_HIST_NUM 32
`define PLE_GAIN_SPLIT 2048
`define PLE_GAIN_ONE 256
`define PLE_DB_MAX 12'd4095
// serial service interval
`define PLE_CLK_HZ 25000000
`define PLE_SVC_US 1000
`define PLE_SVC_CYC ((`PLE_CLK_HZ / 1000000) * `PLE_SVC_US)
// control / status bits
`define PLE_CTRL_GO 0
`define PLE_STAT_BUSY 0
`define PLE_STAT_DONE 1
`define PLE_STAT_HELD 2
`endif

//--- rtl/ple_divider.v
`timescale 1ns/1ps
// sequential signed division, one quotient bit per cycle
module ple_divider #(
    parameter W = 40
) (
    input wire clk_sys,
    input wire rst_b,
    input wire start,
    input wire signed [W-1:0] num,
    input wire signed [W-1:0] den,
    output reg busy,
    output reg signed [W-1:0] quo
);
    reg [W-1:0] rem_reg;
    reg [W-1:0] q_reg;
    reg [W-1:0] d_reg;
    reg neg_reg;
    reg [6:0] n_reg;
    wire [W-1:0] trial = {rem_reg[W-2:0], q_reg[W-1]};
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            quo <= {W{1'b0}};
            rem_reg <= {W{1'b0}};
            q_reg <= {W{1'b0}};
            d_reg <= {W{1'b0}};
            neg_reg <= 1'b0;
            n_reg <= 7'h00;
        end else if (start) begin
            busy <= 1'b1;
            rem_reg <= {W{1'b0}};
            q_reg <= num[W-1] ? -num : num;
            d_reg <= den[W-1] ? -den : den;
            neg_reg <= num[W-1] ^ den[W-1];
            n_reg <= W[6:0];
        end else if (busy) begin
            if (d_reg == {W{1'b0}}) begin
                busy <= 1'b0;
                quo <= {W{1'b0}};
            end else if (n_reg == 7'h00) begin
                busy <= 1'b0;
                quo <= neg_reg ? -q_reg : q_reg;
            end else begin
                if (trial >= d_reg) begin
                    rem_reg <= trial - d_reg;
                    q_reg <= {q_reg[W-2:0], 1'b1};
                end else begin
                    rem_reg <= trial;
                    q_reg <= {q_reg[W-2:0], 1'b0};
                end
                n_reg <= n_reg - 7'h01;
            end
        end
    end
endmodule // ple_divider

//--- rtl/ple_pid_loop_engine.v
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "ple_defs.vh"
module ple_pid_loop_engine #(
    parameter SVC_CYCLES = `PLE_SVC_CYC
) (
    input wire clk_sys,
    input wire rst_b,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire condition_accumulator,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg serial_service
);
    localparam ST_IDLE = 3'd0;
    localparam ST_LOAD = 3'd1;
    localparam ST_COLD = 3'd2;
    localparam ST_CALC = 3'd3;
    localparam ST_DIVW = 3'd4;
    localparam ST_OUT = 3'd5;
    localparam W = 40;

    // counters 256..319 and history blocks; history has no reset
    reg [15:0] cnt_mem [0:`PLE_CNT_NUM-1];
    reg [15:0] hx_mem [0:`PLE_HIST_NUM-1];
    reg [15:0] hy_mem [0:`PLE_HIST_NUM-1];
    reg signed [31:0] hs_mem [0:`PLE_HIST_NUM-1];
    reg [15:0] hw_mem [0:`PLE_HIST_NUM-1];

    reg [31:0] in_reg [0:4];
    reg [2:0] st_reg;
    reg busy_reg, done_reg, held_reg;
    reg [5:0] cnt_addr_reg;
    reg [4:0] hist_sel_reg;
    reg [15:0] svc_cnt_reg;
    reg a_wr_reg, a_rd_reg;
    reg [7:0] a_off_reg;

    reg [15:0] sp, pv, fi, fd, fp, db, ys;
    reg [5:0] ys_idx, pv_idx;
    reg [4:0] blk;
    reg [15:0] maxv;
    reg algo_ext;
    reg signed [W-1:0] y_calc;
    reg div_start;
    reg signed [W-1:0] div_num, div_den;
    wire div_busy;
    wire signed [W-1:0] div_quo;
    wire tick;

    // instruction word layout: in0 = {history_block_select[4:0] at 20:16, res[4:0] at 14:10, op[9:0]}
    wire [9:0] op = in_reg[0][9:0];
    wire [4:0] res = in_reg[0][14:10];
    wire [4:0] history_block_select = in_reg[0][20:16];
    wire [15:0] w_opnd = in_reg[1][15:0];
    wire [8:0] xy_addr = in_reg[1][24:16];

    function [15:0] gain_join;
        input [15:0] word;
        begin
            // multiple of 2048 in the code field, remainder below it
            gain_join = {word[15:11], 11'h000} + {5'h00, word[10:0]};
        end
    endfunction

    function [5:0] cidx;
        input [8:0] a;
        begin
            // window base has its low six bits clear
            cidx = a[5:0];
        end
    endfunction

    // gather operands
    always @* begin
        blk = history_block_select;
        case (res)
            `PLE_RES_8: maxv = 16'h00FF;
            `PLE_RES_15: maxv = 16'h7FFF;
            default: maxv = 16'h0FFF;
        endcase
        if (op == `PLE_OP_BLK) begin
            sp = cnt_mem[cidx(w_opnd[8:0])];
            pv_idx = cidx(w_opnd[8:0]) + 6'd1;
            fi = cnt_mem[cidx(w_opnd[8:0]) + 6'd2];
            fd = cnt_mem[cidx(w_opnd[8:0]) + 6'd3];
            fp = cnt_mem[cidx(w_opnd[8:0]) + 6'd4];
            db = cnt_mem[cidx(w_opnd[8:0]) + 6'd5];
            ys_idx = cidx(w_opnd[8:0]) + 6'd6;
            algo_ext = 1'b0;
        end else begin
            sp = (op == `PLE_OP_CNT) ? cnt_mem[cidx(w_opnd[8:0])]
                : w_opnd;
            pv_idx = cidx(xy_addr);
            fi = gain_join(in_reg[2][15:0]);
            fd = gain_join(in_reg[2][31:16]);
            fp = gain_join(in_reg[3][15:0]);
            db = in_reg[3][31:16] & {4'h0, `PLE_DB_MAX};
            ys_idx = cidx(in_reg[4][8:0]);
            algo_ext = (in_reg[4][23:16] == 8'h01);
        end
        sp = sp & maxv;
        pv = cnt_mem[pv_idx] & maxv;
        ys = cnt_mem[ys_idx] & maxv;
    end

    // velocity form using stored x0, y0 and w0
    always @* begin
        y_calc = $signed({24'h0, hy_mem[blk]}) + ((($signed({24'h0, fp})
            * ($signed({24'h0, sp}) - $signed({24'h0, pv})
            + ((($signed({24'h0, fi}) * $signed({24'h0, sp})
            - $signed({24'h0, fi}) * $signed({24'h0, pv})) >>> 8))
            + (($signed({24'h0, fd}) * ($signed({24'h0, hx_mem[blk]})
            - $signed({24'h0, pv})
            - (algo_ext ? ($signed({24'h0, hw_mem[blk]})
            - $signed({24'h0, sp})) : 40'sd0))) >>> 8))) >>> 8)
            - ((($signed({24'h0, fp}) * ($signed({24'h0, hw_mem[blk]})
            - $signed({24'h0, hx_mem[blk]}))) >>> 8)));
    end

    ple_divider #(.W(W)) u_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(div_start),
        .num(div_num),
        .den(div_den),
        .busy(div_busy),
        .quo(div_quo)
    );

    ple_svc_tick #(.CYCLES(SVC_CYCLES)) u_tick (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick(tick)
    );

    reg [2:0] st_next;
    reg [15:0] yout;
    always @* begin
        st_next = st_reg;
        div_start = 1'b0;
        div_num = ($signed({24'h0, ys}) <<< 8) / $signed({24'h0,
            (fp == 16'h0000) ? 16'h0001 : fp});
        div_num = ((div_num - ($signed({24'h0, sp})
            - $signed({24'h0, pv}))) <<< 8);
        div_den = $signed({24'h0, fi});
        if (y_calc < 40'sd0)
            yout = 16'h0000;
        else if (y_calc > $signed({24'h0, maxv}))
            yout = maxv;
        else
            yout = y_calc[15:0];
        case (st_reg)
            ST_IDLE: st_next = busy_reg ? ST_LOAD : ST_IDLE;
            ST_LOAD: st_next = (ys != 16'h0000) ? ST_COLD : ST_CALC;
            ST_COLD: begin
                div_start = 1'b1;
                st_next = ST_DIVW;
            end
            ST_DIVW: st_next = div_busy ? ST_DIVW : ST_OUT;
            ST_CALC: st_next = ST_OUT;
            ST_OUT: st_next = ST_IDLE;
            default: st_next = ST_IDLE;
        endcase
    end

    wire go_wr = a_wr_reg && a_off_reg == `PLE_OFF_CTRL
        && hwdata[`PLE_CTRL_GO];
    wire cold = (ys != 16'h0000);
    wire [15:0] ydiff = (yout > hy_mem[blk]) ? yout - hy_mem[blk]
        : hy_mem[blk] - yout;
    integer i;

    always @(posedge clk_sys) begin
        if (st_reg == ST_OUT) begin
            hx_mem[blk] <= pv;
            hw_mem[blk] <= sp;
            if (cold) begin
                hy_mem[blk] <= ys;
                hs_mem[blk] <= div_quo[31:0];
            end else if (ydiff > db) begin
                hy_mem[blk] <= yout;
                hs_mem[blk] <= hs_mem[blk] + ((($signed({16'h0, sp})
                    - $signed({16'h0, pv}))));
            end
        end
    end

    always @(posedge clk_sys) begin
        if (st_reg == ST_OUT) begin
            if (cold) begin
                cnt_mem[pv_idx] <= ys;
                cnt_mem[ys_idx] <= 16'h0000;
            end else if (ydiff > db) begin
                cnt_mem[pv_idx] <= yout;
            end
        end else if (a_wr_reg && a_off_reg == `PLE_OFF_CNT_DATA) begin
            cnt_mem[cnt_addr_reg] <= hwdata[15:0];
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            held_reg <= 1'b0;
            cnt_addr_reg <= 6'h00;
            hist_sel_reg <= 5'h00;
            svc_cnt_reg <= 16'h0000;
            a_wr_reg <= 1'b0;
            a_rd_reg <= 1'b0;
            a_off_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            serial_service <= 1'b0;
            for (i = 0; i < 5; i = i + 1)
                in_reg[i] <= 32'h0000_0000;
        end else begin
            st_reg <= st_next;
            a_wr_reg <= hsel && hready && htrans[1] && hwrite;
            a_rd_reg <= hsel && hready && htrans[1] && !hwrite;
            a_off_reg <= haddr[7:0];
            // serial keeps its slot even mid step
            serial_service <= tick;
            if (tick && busy_reg)
                svc_cnt_reg <= svc_cnt_reg + 16'h0001;
            if (st_reg == ST_OUT) begin
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
                held_reg <= !cold && !(ydiff > db);
            end
            // condition accumulator plays no part in starting
            if (go_wr && !busy_reg) begin
                busy_reg <= 1'b1;
                done_reg <= 1'b0;
            end
            if (a_wr_reg && !busy_reg) begin
                case (a_off_reg)
                    `PLE_OFF_INSTR0: in_reg[0] <= hwdata;
                    `PLE_OFF_INSTR1: in_reg[1] <= hwdata;
                    `PLE_OFF_INSTR2: in_reg[2] <= hwdata;
                    `PLE_OFF_INSTR3: in_reg[3] <= hwdata;
                    `PLE_OFF_INSTR4: in_reg[4] <= hwdata;
                    `PLE_OFF_HIST_SEL: hist_sel_reg <= hwdata[4:0];
                    default: ;
                endcase
            end
            if (a_wr_reg && a_off_reg == `PLE_OFF_CNT_ADDR)
                cnt_addr_reg <= cidx(hwdata[8:0]);
            if (hsel && hready && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    `PLE_OFF_STATUS: hrdata <= {29'h0, held_reg,
                        done_reg, busy_reg};
                    `PLE_OFF_INSTR0: hrdata <= in_reg[0];
                    `PLE_OFF_INSTR1: hrdata <= in_reg[1];
                    `PLE_OFF_INSTR2: hrdata <= in_reg[2];
                    `PLE_OFF_INSTR3: hrdata <= in_reg[3];
                    `PLE_OFF_INSTR4: hrdata <= in_reg[4];
                    `PLE_OFF_CNT_ADDR: hrdata <= {26'h0, cnt_addr_reg};
                    `PLE_OFF_CNT_DATA: hrdata <= {16'h0,
                        cnt_mem[cnt_addr_reg]};
                    `PLE_OFF_HIST_SEL: hrdata <= {16'h0,
                        hy_mem[hist_sel_reg]};
                    `PLE_OFF_SVC_CNT: hrdata <= {16'h0, svc_cnt_reg};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // ple_pid_loop_engine

//--- rtl/ple_svc_tick.v
`timescale 1ns/1ps
`include "ple_defs.vh"
// periodic pulse used to service the serial side during long steps
module ple_svc_tick #(
    parameter CYCLES = `PLE_SVC_CYC
) (
    input wire clk_sys,
    input wire rst_b,
    output reg tick
);
    reg [15:0] cnt_reg;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt_reg == CYCLES[15:0] - 16'h0001) begin
            cnt_reg <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule // ple_svc_tick
